/* hw/ext_contact_pkg.sv */
// shared constants and carrier types for the rear contact control block
`default_nettype none
package ext_contact_pkg;
   // contact logic modes
   localparam logic [1:0] LOGIC_HIGH_ON  = 2'h0;
   localparam logic [1:0] LOGIC_LOW_ON   = 2'h1;
   localparam logic [1:0] LOGIC_DISABLED = 2'h2;
   localparam logic [1:0] LOGIC_RESET    = 2'h2;
   // debounce time and derived cycle count at 125 MHz
   localparam int DEBOUNCE_US      = 2;
   localparam int CLK_MHZ          = 125;
   localparam int DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
   localparam int DEB_W            = 8;

   typedef struct packed {
      logic overvoltage_trip;
      logic hardware_overvoltage_trip;
      logic overcurrent_trip;
      logic overtemperature_trip;
      logic mains_failure_trip;
      logic overpower_trip;
   } trip_t;

   typedef struct packed {
      logic alarm_n;
      logic cv_n;
      logic power_off_n;
      logic cc_n;
      logic output_on_n;
   } status_t;

   typedef enum logic [2:0] {
      ST_OFF      = 3'h1,
      ST_ON       = 3'h2,
      ST_SHUTDOWN = 3'h4
   } out_state_t;
endpackage
`default_nettype wire

/* hw/ext_contact_control_status.sv */
// output on/off, shutdown latch, alarm clear and status pins for the rear contacts
//
// Notes on behaviour
// - in high-on mode a key press with the contact low leaves output off and flags message one.
// - in low-on mode a key press with the contact high leaves output off and flags message two.
// - under contact control the programmed on and off delays are skipped.
// - a low shutdown contact forces the output off and latches the shutdown.
// - the latch releases only after the contact is open again and alarm clear is held, or reset.
// - shutdown and alarm-clear contacts are always live with no enable setting.
// - shutdown only disables the output stage, never the instrument itself.
// - a low alarm-clear contact clears the latched protection alarm.
// - the alarm status is on while any trip is latched or shutdown is applied.
// - cv status follows cv regulation and cc status follows cc regulation, only while the output is enabled.
// - the power-off status drives low when the instrument powers down.
// - the output-on status is on exactly while the output is enabled.
// - all five status outputs are active low.
// - the logic setting selects high-on (0), low-on (1) or no contact control (2).
// - the logic setting is sampled only once after power-up reset.
`default_nettype none
module ext_contact_control_status
   import ext_contact_pkg::*;
(
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        onoff_contact_i,
   input  wire logic                        shutdown_contact_n_i,
   input  wire logic                        alarm_clear_contact_n_i,
   input  wire logic [1:0]                  contact_logic_cfg_i,
   input  wire logic                        output_key_i,
   input  wire logic                        alarm_clear_key_i,
   input  wire logic                        on_delay_done_i,
   input  wire logic                        off_delay_done_i,
   input  wire ext_contact_pkg::trip_t      trip_i,
   input  wire logic                        cv_mode_i,
   input  wire logic                        cc_mode_i,
   input  wire logic                        power_failing_i,
   output logic                             output_enable_o,
   output logic                             msg_expected_high_level_o,
   output logic                             msg_expected_low_level_o,
   output ext_contact_pkg::status_t         status_o
);
   import ext_contact_pkg::*;

   // flow: pins, two-flop sync, debounce, mode decode, output state machine,
   // then registered enable and status lines; every output leaves a flop

   // debounce counter reload value, sized to its counter
   localparam logic [DEB_W-1:0] DEB_LOAD = DEB_W'(DEBOUNCE_CYCLES - 1);

   // two-stage synchronisers for the three contact pins
   // only the second stage feeds logic; the first may still be settling
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] raw;
   assign raw = {onoff_contact_i, shutdown_contact_n_i, alarm_clear_contact_n_i};

   // debounced levels, held as open (high) from reset like the pull-ups
   logic [2:0]       deb;
   logic [2:0]       next_deb;
   logic [DEB_W-1:0] deb_cnt [3];
   logic [DEB_W-1:0] next_deb_cnt [3];

   // sampled-once configuration
   logic [1:0] mode;
   logic [1:0] next_mode;
   logic       mode_loaded;
   logic       next_mode_loaded;

   // output control state
   out_state_t state;
   out_state_t next_state;
   logic       key_q;
   logic       key_pulse;
   logic       trips_latched;
   logic       next_trips_latched;
   logic       msg_hi;
   logic       next_msg_hi;
   logic       msg_lo;
   logic       next_msg_lo;
   status_t    next_status;
   logic       next_out_en;

   logic onoff_db;
   logic shut_db_n;
   logic clr_db_n;
   logic ext_ctrl;
   logic contact_wants_on;
   logic clear_req;
   logic shutdown_active;

   // counts a stable new level before accepting it; ties the count to the level
   function automatic logic stable_done(input logic [DEB_W-1:0] cnt);
      stable_done = (cnt == '0);
   endfunction

   // any protection source active this cycle
   function automatic logic any_trip(input trip_t t);
      any_trip = |t;
   endfunction

   // contact level that asks for output on under the given mode
   function automatic logic contact_says_on(input logic [1:0] m, input logic level);
      contact_says_on = (m == LOGIC_HIGH_ON) ? level : !level;
   endfunction

   // pins rest open through their pull-ups, so the flops reset to ones
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_a <= 3'h7;
         sync_b <= 3'h7;
      end else begin
         sync_a <= raw;
         sync_b <= sync_a;
      end
   end

   // debounce: a level change must hold for the full count before it is taken
   // 2 us costs little delay but rides out relay chatter
   always_comb begin
      next_deb = deb;
      for (int i = 0; i < 3; i++) begin
         next_deb_cnt[i] = deb_cnt[i];
         if (sync_b[i] == deb[i]) begin
            next_deb_cnt[i] = DEB_LOAD;
         end else if (stable_done(deb_cnt[i])) begin
            next_deb[i]     = sync_b[i];
            next_deb_cnt[i] = DEB_LOAD;
         end else begin
            next_deb_cnt[i] = deb_cnt[i] - 1'b1;
         end
      end
   end

   // counters start full so the first change needs the whole window
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         deb <= 3'h7;
         for (int i = 0; i < 3; i++) begin
            deb_cnt[i] <= DEB_LOAD;
         end
      end else begin
         deb <= next_deb;
         for (int i = 0; i < 3; i++) begin
            deb_cnt[i] <= next_deb_cnt[i];
         end
      end
   end

   assign onoff_db  = deb[2];
   assign shut_db_n = deb[1];
   assign clr_db_n  = deb[0];

   // setting is caught once after reset release; later edits wait for power cycle
   // a setting of 3 falls back to no contact control
   always_comb begin
      next_mode        = mode;
      next_mode_loaded = 1'b1;
      if (!mode_loaded) begin
         next_mode = (contact_logic_cfg_i > LOGIC_DISABLED) ? LOGIC_DISABLED
                                                            : contact_logic_cfg_i;
      end
   end

   // reset stands for a power cycle, the only way to change the setting
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode        <= LOGIC_RESET;
         mode_loaded <= 1'b0;
      end else begin
         mode        <= next_mode;
         mode_loaded <= next_mode_loaded;
      end
   end

   // mode decode: contact control unless disabled
   assign ext_ctrl         = mode_loaded && (mode != LOGIC_DISABLED);
   assign contact_wants_on = contact_says_on(mode, onoff_db);
   // rising edge of the key; a held key counts once
   assign key_pulse        = output_key_i && !key_q;
   // clear sources need no enable: both the key and the contact act at any time
   assign clear_req        = alarm_clear_key_i || !clr_db_n;
   // shutdown shows as alarm from the pin and for as long as the latch holds
   assign shutdown_active  = !shut_db_n || (state == ST_SHUTDOWN);

   // output state machine; shutdown is checked first so it wins over everything
   always_comb begin
      next_state  = state;
      next_msg_hi = 1'b0;
      next_msg_lo = 1'b0;
      case (state)
         ST_OFF: begin
            if (!shut_db_n) begin
               next_state = ST_SHUTDOWN;
            end else if (ext_ctrl) begin
               // a latched or fresh trip keeps the contact from restarting the output
               if (contact_wants_on && !trips_latched && !any_trip(trip_i)) begin
                  next_state = ST_ON;
               end else if (key_pulse && !contact_wants_on) begin
                  // refused press: tell the panel which level was expected
                  next_msg_hi = (mode == LOGIC_HIGH_ON);
                  next_msg_lo = (mode == LOGIC_LOW_ON);
               end
            end else if (key_pulse && on_delay_done_i && !trips_latched) begin
               // key mode honours the programmed on delay
               next_state = ST_ON;
            end
         end
         ST_ON: begin
            if (!shut_db_n) begin
               next_state = ST_SHUTDOWN;
            end else if (trips_latched) begin
               // a trip drops the output; key mode needs a fresh press, contact control returns once the latch clears if the contact still asks for on
               next_state = ST_OFF;
            end else if (ext_ctrl) begin
               if (!contact_wants_on) begin
                  next_state = ST_OFF;
               end
            end else if (key_pulse && off_delay_done_i) begin
               // key mode honours the programmed off delay
               next_state = ST_OFF;
            end
         end
         ST_SHUTDOWN: begin
            // contact open again and a clear held; reset also leaves here
            // key presses are ignored until the latch lets go
            if (shut_db_n && clear_req) begin
               next_state = ST_OFF;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
   end

   // protection latch: a trip in the clear cycle stays set
   // the set wins so a trip arriving with a clear is never lost
   always_comb begin
      next_trips_latched = trips_latched;
      if (clear_req) begin
         next_trips_latched = 1'b0;
      end
      if (any_trip(trip_i)) begin
         next_trips_latched = 1'b1;
      end
   end

   // shutdown only gates the output stage; the control logic keeps running
   // a trip in this very cycle blocks the enable before the latch has caught it
   assign next_out_en = (next_state == ST_ON) && !any_trip(trip_i);

   // status lines, low means asserted
   // cv and cc report only while the stage is on
   always_comb begin
      next_status.alarm_n     = !(next_trips_latched || shutdown_active);
      next_status.cv_n        = !(cv_mode_i && next_out_en);
      next_status.cc_n        = !(cc_mode_i && next_out_en);
      next_status.power_off_n = !power_failing_i;
      next_status.output_on_n = !next_out_en;
   end

   // control state: output machine, key history and trip latch
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state         <= ST_OFF;
         key_q         <= 1'b0;
         trips_latched <= 1'b0;
      end else begin
         state         <= next_state;
         key_q         <= output_key_i;
         trips_latched <= next_trips_latched;
      end
   end

   // refused-press messages, one cycle per press
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         msg_hi <= 1'b0;
         msg_lo <= 1'b0;
      end else begin
         msg_hi <= next_msg_hi;
         msg_lo <= next_msg_lo;
      end
   end

   // pin-facing flops; reset shows everything idle and power-off low
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         output_enable_o <= 1'b0;
         status_o        <= 5'h1B;  // only power_off_n low
      end else begin
         output_enable_o <= next_out_en;
         status_o        <= next_status;
      end
   end

   // message pins are the pulse flops themselves
   assign msg_expected_high_level_o = msg_hi;
   assign msg_expected_low_level_o  = msg_lo;
endmodule
`default_nettype wire

/* bench/ext_contact_properties.sv */
// assertions on the rear contact control block ports
`default_nettype none
module ext_contact_properties
   import ext_contact_pkg::*;
(
   input wire logic                     core_clk_i,
   input wire logic                     rst_n_i,
   input wire logic                     shutdown_contact_n_i,
   input wire logic                     alarm_clear_contact_n_i,
   input wire logic                     alarm_clear_key_i,
   input wire ext_contact_pkg::trip_t   trip_i,
   input wire logic                     cv_mode_i,
   input wire logic                     cc_mode_i,
   input wire logic                     power_failing_i,
   input wire logic                     output_enable_o,
   input wire logic                     msg_expected_high_level_o,
   input wire logic                     msg_expected_low_level_o,
   input wire ext_contact_pkg::status_t status_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import ext_contact_pkg::*;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   int unsigned sd_low;
   int unsigned clr_age;
   // raw shutdown low time and age of the last clear request
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sd_low  <= 0;
         clr_age <= 1000;
      end else begin
         sd_low  <= shutdown_contact_n_i ? 0 : sd_low + 1;
         clr_age <= (alarm_clear_key_i || !alarm_clear_contact_n_i) ? 0 : clr_age + 1;
      end
   end
   // a refused key press leaves the output off and pulses once
   sequence off_then_quiet(logic m);
      !output_enable_o ##1 !m;
   endsequence
   chk_msg_high_off: assert property (
      msg_expected_high_level_o |-> off_then_quiet(msg_expected_high_level_o))
      else $error("high level message with output on");
   chk_msg_low_off: assert property (
      msg_expected_low_level_o |-> off_then_quiet(msg_expected_low_level_o))
      else $error("low level message with output on");
   chk_sd_forces_off: assert property (
      sd_low > DEBOUNCE_CYCLES + 8 |-> !output_enable_o && !status_o.alarm_n)
      else $error("shutdown held but output still on");
   chk_alarm_release: assert property ($rose(status_o.alarm_n) |-> clr_age < 300)
      else $error("alarm released without a clear");
   chk_trip_alarm: assert property (|trip_i |-> ##[1:2] !status_o.alarm_n)
      else $error("trip did not raise alarm");
   chk_cv_status: assert property (!status_o.cv_n |-> $past(cv_mode_i))
      else $error("cv status without cv regulation");
   chk_cc_status: assert property (!status_o.cc_n |-> $past(cc_mode_i))
      else $error("cc status without cc regulation");
   chk_alarm_holds_off: assert property (!status_o.alarm_n |-> !output_enable_o)
      else $error("output on while alarm is raised");
   chk_power_off: assert property (power_failing_i |-> ##[1:2] !status_o.power_off_n)
      else $error("power-off status not driven low");
   chk_out_on_pin: assert property (
      $changed(output_enable_o) |-> ##[0:1] (status_o.output_on_n != output_enable_o))
      else $error("output-on status does not follow output");
endmodule
bind ext_contact_control_status ext_contact_properties chk (.*);
`default_nettype wire

/* bench/contact_switches.sv */
// behavioural model of the rear contact switches
`default_nettype none
module contact_switches (
   input  wire logic       clk_i,
   input  wire logic [2:0] want_i,
   output var  logic [2:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] last = 3'h7;
   logic [2:0] mv   = 3'h0;
   int         left = 0;
   int         seed = 32'hA8CA;
   // open contacts rest at the pull-up level
   initial pin_o = 3'h7;
   // moving contacts chatter a few cycles before settling
   always @(posedge clk_i) begin
      if (want_i !== last) begin
         mv = want_i ^ last;
         last = want_i;
         left = 2 + ($unsigned($random(seed)) % 6);
      end
      pin_o <= (left > 0) ? (last ^ (mv & 3'($random(seed)))) : last;
      if (left > 0)
         left--;
   end
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the rear contact control block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ext_contact_pkg::*;
   logic       core_clk_i = 0, rst_n_i = 0, output_key_i = 0, alarm_clear_key_i = 0;
   logic       on_delay_done_i = 0, off_delay_done_i = 0, cv_mode_i = 0, cc_mode_i = 0;
   logic       power_failing_i = 0, look = 0, clr_msg = 0;
   logic       onoff_contact_i, shutdown_contact_n_i, alarm_clear_contact_n_i;
   logic       output_enable_o, msg_expected_high_level_o, msg_expected_low_level_o;
   logic [1:0] contact_logic_cfg_i = 2'h0, msg_seen = 2'h0;
   logic [2:0] want = 3'h7;
   trip_t      trip_i = '0;
   status_t    status_o;
   logic [7:0] exp_q[$];
   int         err_count = 0, n_checks = 0, cycles = 0, seed = 32'hA8CA;

   ext_contact_control_status dut (.*);
   contact_switches sw (.clk_i(core_clk_i), .want_i(want),
      .pin_o({onoff_contact_i, shutdown_contact_n_i, alarm_clear_contact_n_i}));

   initial forever #4 core_clk_i = ~core_clk_i;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic compare(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // wait out sync and debounce, then leave a note for the monitor
   task automatic expect_out(input logic en, input logic alm, input logic [1:0] m);
      tick(DEBOUNCE_CYCLES + 30);
      exp_q.push_back({en, alm, !(cv_mode_i && en), !power_failing_i, !(cc_mode_i && en),
                       !en, m});
      look <= 1'b1;
      tick(1);
      look <= 1'b0;
      clr_msg <= 1'b1;
      tick(1);
      clr_msg <= 1'b0;
   endtask
   task automatic press();
      output_key_i <= 1'b1;
      tick(2);
      output_key_i <= 1'b0;
      tick(2);
   endtask
   task automatic restart(input logic [1:0] cfg);
      contact_logic_cfg_i <= cfg;
      rst_n_i <= 1'b0;
      tick(3);
      // reset shows idle pins with only the power-off status low
      exp_q.push_back(8'h6C);
      look <= 1'b1;
      tick(1);
      look <= 1'b0;
      rst_n_i <= 1'b1;
      tick(DEBOUNCE_CYCLES + 30);
   endtask

   // monitor: message pulses are latched so a later look still sees them
   always @(posedge core_clk_i) begin
      cycles++;
      msg_seen <= clr_msg ? 2'h0 : msg_seen | {msg_expected_high_level_o, msg_expected_low_level_o};
      if (look)
         compare({output_enable_o, status_o, msg_seen}, exp_q.pop_front());
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end

   // want bits: on/off contact, shutdown, alarm clear; low means shorted
   initial begin
      restart(LOGIC_HIGH_ON);
      want <= 3'h3;
      expect_out(0, 1, 2'h0);
      press();
      expect_out(0, 1, 2'h2);
      want <= 3'h7;
      contact_logic_cfg_i <= LOGIC_LOW_ON;
      expect_out(1, 1, 2'h0);
      want <= 3'h5;
      tick(40);
      want <= 3'h7;
      expect_out(1, 1, 2'h0);
      want <= 3'h5;
      expect_out(0, 0, 2'h0);
      want <= 3'h7;
      press();
      expect_out(0, 0, 2'h0);
      want <= 3'h3;
      alarm_clear_key_i <= 1'b1;
      tick(4);
      alarm_clear_key_i <= 1'b0;
      expect_out(0, 1, 2'h0);
      $display("high-on mode done");
      want <= 3'h7;
      restart(LOGIC_LOW_ON);
      press();
      expect_out(0, 1, 2'h1);
      want <= 3'h3;
      cv_mode_i <= 1'b1;
      expect_out(1, 1, 2'h0);
      trip_i <= trip_t'(6'h01 << ($unsigned($random(seed)) % 6));
      tick(2);
      trip_i <= '0;
      want <= 3'h7;
      expect_out(0, 0, 2'h0);
      want <= 3'h6;
      expect_out(0, 1, 2'h0);
      want <= 3'h3;
      cv_mode_i <= 1'b0;
      cc_mode_i <= 1'b1;
      expect_out(1, 1, 2'h0);
      want <= 3'h7;
      power_failing_i <= 1'b1;
      expect_out(0, 1, 2'h0);
      power_failing_i <= 1'b0;
      $display("low-on mode done");
      restart(LOGIC_DISABLED);
      on_delay_done_i <= 1'b1;
      want <= 3'h3;
      press();
      expect_out(1, 1, 2'h0);
      off_delay_done_i <= 1'b1;
      press();
      expect_out(0, 1, 2'h0);
      $display("key mode done");
      complete_run();
   end
endmodule
`default_nettype wire
